//--- hdl/ssm_bank.sv
// supply fault flags, fault alert mask and supply enable gate registers
`timescale 1ns/1ps
`include "ssm_cfg.svh"

module ssm_bank (
	input  wire logic              sys_clk,
	input  wire logic              rst_b,
	input  wire logic              undervoltage_lockout,
	input  wire ssm_pkg::ssm_raw_s raw_in,
	input  wire logic [6:0]        slave_addr,
	input  wire ssm_pkg::ssm_acc_s acc,
	output logic [7:0]             rdata,
	output logic                   rvalid,
	output logic [4:0]             supply_on,
	output logic                   alert_oe
);
	ssm_pkg::ssm_state_s st_r;
	ssm_pkg::ssm_state_s st_nxt;

	// ============================================================
	// helpers
	function automatic logic [7:0] flag_calc(input ssm_pkg::ssm_raw_s s,
		input logic [4:0] on);
		logic [7:0] f;
		f = `SSM_RST_ZERO;
		f[`SSM_BIT_PFAIL] = s.pfail;
		f[`SSM_BIT_LBAT]  = s.lbat;
		f[`SSM_BIT_BUCK1] = s.buck_pg_low[0] & on[4];
		f[`SSM_BIT_BUCK2] = s.buck_pg_low[1] & on[3];
		f[`SSM_BIT_BUCK3] = s.buck_pg_low[2] & on[2]
			& ~s.dvs_busy;
		f[`SSM_BIT_LREG2] = s.lreg_pg_low[1] & on[1];
		f[`SSM_BIT_LREG1] = s.lreg_pg_low[0] & on[0];
		return f;
	endfunction

	// ============================================================
	// next state
	logic       hit;
	logic       fault;
	logic [7:0] ena_w;
	always_comb begin
		st_nxt = st_r;
		// second stage only reads first stage
		st_nxt.sy1 = raw_in;
		st_nxt.sy2 = st_r.sy1;
		hit = (slave_addr == `SSM_SLAVE_ADDR);
		ena_w = st_r.enab;
		if (hit && acc.wr && acc.addr == `SSM_OFS_MASK)
			st_nxt.mask = acc.wdata & `SSM_MASK_WR;
		if (hit && acc.wr && acc.addr == `SSM_OFS_ENABLE)
			ena_w = (acc.wdata & `SSM_ENA_WR) | `SSM_ENA_FIXED;
		// pin-low hold wins over a host write of 0
		if (!st_r.sy2.buck_pin[0]) ena_w[`SSM_BIT_BUCK1] = 1'b1;
		if (!st_r.sy2.buck_pin[1]) ena_w[`SSM_BIT_BUCK2] = 1'b1;
		if (!st_r.sy2.buck_pin[2]) ena_w[`SSM_BIT_BUCK3] = 1'b1;
		if (!st_r.sy2.lreg_pin) begin
			ena_w[`SSM_BIT_LREG2] = 1'b1;
			ena_w[`SSM_BIT_LREG1] = 1'b1;
		end
		if (undervoltage_lockout)
			ena_w = `SSM_RST_ENABLE;
		st_nxt.enab = ena_w;
		st_nxt.supply_on = {st_r.enab[`SSM_BIT_BUCK1] & st_r.sy2.buck_pin[0],
			st_r.enab[`SSM_BIT_BUCK2] & st_r.sy2.buck_pin[1],
			st_r.enab[`SSM_BIT_BUCK3] & st_r.sy2.buck_pin[2],
			st_r.enab[`SSM_BIT_LREG2] & st_r.sy2.lreg_pin,
			st_r.enab[`SSM_BIT_LREG1] & st_r.sy2.lreg_pin};
		st_nxt.flags = flag_calc(st_r.sy2, st_r.supply_on);
		fault = |(st_r.flags & ~st_r.mask);
		st_nxt.rvalid = hit && acc.rd;
		st_nxt.rdata = st_r.rdata;
		if (hit && acc.rd) begin
			case (acc.addr)
				`SSM_OFS_FLAGS:  st_nxt.rdata = st_r.flags;
				`SSM_OFS_MASK:   st_nxt.rdata = st_r.mask;
				`SSM_OFS_ENABLE: st_nxt.rdata = st_r.enab;
				default:         st_nxt.rdata = `SSM_UNMAPPED;
			endcase
		end
		case (st_r.alert)
			ssm_pkg::SSM_ALERT_IDLE:
				if (fault) st_nxt.alert = ssm_pkg::SSM_ALERT_LOW;
			ssm_pkg::SSM_ALERT_LOW:
				if (!fault)
					st_nxt.alert = ssm_pkg::SSM_ALERT_IDLE;
				else if (hit && acc.rd && acc.addr == `SSM_OFS_FLAGS)
					st_nxt.alert = ssm_pkg::SSM_ALERT_ACKD;
			ssm_pkg::SSM_ALERT_ACKD:
				// stays released until no unmasked fault remains; masked faults do not hold it
				if (!fault) st_nxt.alert = ssm_pkg::SSM_ALERT_IDLE;
			default: st_nxt.alert = ssm_pkg::SSM_ALERT_IDLE;
		endcase
		st_nxt.alert_oe = (st_nxt.alert == ssm_pkg::SSM_ALERT_LOW);
	end

	// ============================================================
	// state register
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_r <= '0;
			st_r.mask <= `SSM_RST_MASK;
			st_r.enab <= `SSM_RST_ENABLE;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign rdata     = st_r.rdata;
	assign rvalid    = st_r.rvalid;
	assign supply_on = st_r.supply_on;
	assign alert_oe  = st_r.alert_oe;

	// ============================================================
	// checks
	chk_flag_zero: assert property (@(posedge sys_clk) disable iff (!rst_b)
		st_r.flags[0] == 1'b0) else $error("flag bit 0 set");
	chk_pfail_follow: assert property (@(posedge sys_clk) disable iff (!rst_b)
		st_r.sy2.pfail |=> st_r.flags[`SSM_BIT_PFAIL])
		else $error("power fail flag missed");
	chk_lbat_follow: assert property (@(posedge sys_clk) disable iff (!rst_b)
		!st_r.sy2.lbat |=> !st_r.flags[`SSM_BIT_LBAT])
		else $error("low battery flag stuck");
	chk_off_flag: assert property (@(posedge sys_clk) disable iff (!rst_b)
		!st_r.supply_on[4] |=> !st_r.flags[`SSM_BIT_BUCK1])
		else $error("disabled buck flagged");
	chk_dvs_blank: assert property (@(posedge sys_clk) disable iff (!rst_b)
		st_r.sy2.dvs_busy |=> !st_r.flags[`SSM_BIT_BUCK3])
		else $error("flag during scaling");
	chk_mask_low: assert property (@(posedge sys_clk) disable iff (!rst_b)
		st_r.mask[0] == 1'b0) else $error("mask bit 0 set");
	chk_supply_and: assert property (@(posedge sys_clk) disable iff (!rst_b)
		!st_r.sy2.lreg_pin |=> !st_r.supply_on[0])
		else $error("regulator on with pin low");
	chk_undervoltage_lockout_load: assert property (@(posedge sys_clk) disable iff (!rst_b)
		undervoltage_lockout |=> st_r.enab == `SSM_RST_ENABLE)
		else $error("lockout did not load ones");
	chk_pin_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
		!st_r.sy2.buck_pin[0] |=> st_r.enab[`SSM_BIT_BUCK1])
		else $error("enable not held");
	chk_fixed_ones: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(st_r.enab & `SSM_ENA_FIXED) == `SSM_ENA_FIXED)
		else $error("fixed enable bits lost");
	chk_alert_src: assert property (@(posedge sys_clk) disable iff (!rst_b)
		alert_oe |-> $past(|(st_r.flags & ~st_r.mask)))
		else $error("alert without fault");
	chk_read_release: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(alert_oe && acc.rd && acc.addr == `SSM_OFS_FLAGS
			&& slave_addr == `SSM_SLAVE_ADDR) |=> !alert_oe)
		else $error("read did not release alert");
	cov_alert: cover property (@(posedge sys_clk) disable iff (!rst_b)
		!alert_oe ##1 alert_oe);
	cov_ack: cover property (@(posedge sys_clk) disable iff (!rst_b)
		st_r.alert == ssm_pkg::SSM_ALERT_ACKD);
	cov_wr_ena: cover property (@(posedge sys_clk) disable iff (!rst_b)
		acc.wr && acc.addr == `SSM_OFS_ENABLE && acc.wdata == 8'h00);

	// ============================================================
	// per-supply checks; each buck and regulator flag has its own gate, so each is watched
	chk_lbat_set: assert property (@(posedge sys_clk) disable iff (!rst_b)
		st_r.sy2.lbat |=> st_r.flags[`SSM_BIT_LBAT])
		else $error("low battery flag missed");
	chk_buck2_off: assert property (@(posedge sys_clk) disable iff (!rst_b)
		!st_r.supply_on[3] |=> !st_r.flags[`SSM_BIT_BUCK2])
		else $error("disabled buck two flagged");
	chk_buck3_off: assert property (@(posedge sys_clk) disable iff (!rst_b)
		!st_r.supply_on[2] |=> !st_r.flags[`SSM_BIT_BUCK3])
		else $error("disabled buck three flagged");
	chk_lreg2_off: assert property (@(posedge sys_clk) disable iff (!rst_b)
		!st_r.supply_on[1] |=> !st_r.flags[`SSM_BIT_LREG2])
		else $error("disabled regulator two flagged");
	chk_lreg1_off: assert property (@(posedge sys_clk) disable iff (!rst_b)
		!st_r.supply_on[0] |=> !st_r.flags[`SSM_BIT_LREG1])
		else $error("disabled regulator one flagged");
	chk_buck_gate: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(!st_r.enab[`SSM_BIT_BUCK1] || !st_r.sy2.buck_pin[0])
		|=> !st_r.supply_on[4])
		else $error("buck one on while gated");
	chk_lreg_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
		!st_r.sy2.lreg_pin |=> (st_r.enab[`SSM_BIT_LREG2]
			&& st_r.enab[`SSM_BIT_LREG1]))
		else $error("regulator enable not held");

	// ============================================================
	// register access and alert checks
	chk_mask_write: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(slave_addr == `SSM_SLAVE_ADDR && acc.wr
			&& acc.addr == `SSM_OFS_MASK)
		|=> st_r.mask == ($past(acc.wdata) & `SSM_MASK_WR))
		else $error("mask write lost");
	chk_read_valid: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(slave_addr == `SSM_SLAVE_ADDR && acc.rd) |=> rvalid)
		else $error("read not answered");
	chk_other_addr: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(slave_addr != `SSM_SLAVE_ADDR) |=> !rvalid)
		else $error("answered other address");
	chk_rdata_flags: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(slave_addr == `SSM_SLAVE_ADDR && acc.rd
			&& acc.addr == `SSM_OFS_FLAGS)
		|=> rdata == $past(st_r.flags))
		else $error("status read wrong");
	// a fresh fault must pull the pin; with no unmasked fault the pin must be released
	chk_alert_rise: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(st_r.alert == ssm_pkg::SSM_ALERT_IDLE
			&& |(st_r.flags & ~st_r.mask)) |=> alert_oe)
		else $error("fault did not raise alert");
	chk_alert_drop: assert property (@(posedge sys_clk) disable iff (!rst_b)
		!(|(st_r.flags & ~st_r.mask)) |=> !alert_oe)
		else $error("alert held without fault");
	cov_undervoltage_lockout: cover property (@(posedge sys_clk) disable iff (!rst_b)
		undervoltage_lockout);
	cov_dvs: cover property (@(posedge sys_clk) disable iff (!rst_b)
		st_r.sy2.dvs_busy && st_r.sy2.buck_pg_low[2]);
endmodule

//--- hdl/ssm_cfg.svh
// offsets, field positions, reset values and address of the supply bank
`ifndef SSM_CFG_SVH
`define SSM_CFG_SVH
`define SSM_OFS_FLAGS     8'h01
`define SSM_OFS_MASK      8'h02
`define SSM_OFS_ENABLE    8'h03
`define SSM_RST_MASK      8'hC0
`define SSM_RST_ENABLE    8'hFF
`define SSM_RST_ZERO      8'h00
`define SSM_UNMAPPED      8'hFF
`define SSM_MASK_WR       8'hFE
`define SSM_ENA_WR        8'h3E
`define SSM_ENA_FIXED     8'hC1
`define SSM_BIT_PFAIL     7
`define SSM_BIT_LBAT      6
`define SSM_BIT_BUCK1     5
`define SSM_BIT_BUCK2     4
`define SSM_BIT_BUCK3     3
`define SSM_BIT_LREG2     2
`define SSM_BIT_LREG1     1
`define SSM_SLAVE_ADDR    7'h48
`endif

//--- hdl/ssm_pkg.sv
// types shared by the supply status, mask and enable bank
package ssm_pkg;
	typedef struct packed {
		logic       pfail;
		logic       lbat;
		logic [2:0] buck_pin;
		logic       lreg_pin;
		logic [2:0] buck_pg_low;
		logic [1:0] lreg_pg_low;
		logic       dvs_busy;
	} ssm_raw_s;
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} ssm_acc_s;
	typedef enum logic [1:0] {
		SSM_ALERT_IDLE = 2'b00,
		SSM_ALERT_LOW  = 2'b01,
		SSM_ALERT_ACKD = 2'b10
	} ssm_alert_e;
	typedef struct packed {
		ssm_raw_s   sy1;
		ssm_raw_s   sy2;
		logic [7:0] flags;
		logic [7:0] mask;
		logic [7:0] enab;
		logic [4:0] supply_on;
		logic [7:0] rdata;
		logic       rvalid;
		logic       alert_oe;
		ssm_alert_e alert;
	} ssm_state_s;
endpackage

//--- testbench/ssm_far_model.sv
// comparator and enable pin model feeding the raw inputs of the supply bank
`timescale 1ns/1ps
// ============================================================
// far side: analog comparators and board enable pins
module ssm_far_model (
	input  wire logic              sys_clk,
	input  wire ssm_pkg::ssm_raw_s want,
	output ssm_pkg::ssm_raw_s      raw
);
	initial raw = '0;
	// levels move just after the edge, like an analog threshold crossing
	always @(posedge sys_clk) begin
		raw <= #1 want;
	end
endmodule

//--- testbench/supply_status_mask_enable_regs_tb_top.sv
// self-checking bench for the supply status, mask and enable bank
`timescale 1ns/1ps
`include "ssm_cfg.svh"
// ============================================================
// bench
module supply_status_mask_enable_regs_tb_top;
	logic              sys_clk = 0;
	logic              rst_b   = 0;
	logic              undervoltage_lockout = 0;
	logic [6:0]        sa      = `SSM_SLAVE_ADDR;
	ssm_pkg::ssm_acc_s acc     = '0;
	ssm_pkg::ssm_raw_s want, raw;
	logic [7:0]        rdata, v;
	logic              rvalid, alert_oe;
	logic [4:0]        supply_on;
	int                errors = 0;
	int                samples_checked = 0;

	always #50 sys_clk = ~sys_clk;

	ssm_far_model far (.sys_clk(sys_clk), .want(want), .raw(raw));
	ssm_bank uut (.sys_clk(sys_clk), .rst_b(rst_b),
		.undervoltage_lockout(undervoltage_lockout), .raw_in(raw),
		.slave_addr(sa),
		.acc(acc), .rdata(rdata), .rvalid(rvalid),
		.supply_on(supply_on), .alert_oe(alert_oe));

	task chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task finish_test;
		$display("errors=%0d samples_checked=%0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// ============================================================
	// access tasks: request held until the taking edge
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk) #1;
		acc.wr = 1;
		acc.addr = a;
		acc.wdata = d;
		@(posedge sys_clk) #1;
		acc.wr = 0;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge sys_clk) #1;
		acc.rd = 1;
		acc.addr = a;
		@(posedge sys_clk) #1;
		acc.rd = 0;
		chk({7'h0, rvalid}, 8'h01);
		chk(rdata, exp);
	endtask
	// sync plus pipeline is about four cycles; six leaves margin
	task settle;
		repeat (6) @(posedge sys_clk);
		#1;
	endtask
	task alert(input logic e);
		chk({7'h0, alert_oe}, {7'h0, e});
	endtask

	initial begin
		repeat (5000) @(posedge sys_clk);
		errors++;
		finish_test();
	end
	// ============================================================
	// scenarios
	initial begin
		want = '0;
		want.buck_pin = 3'b111;
		want.lreg_pin = 1;
		repeat (10) @(posedge sys_clk);
		#1 rst_b = 1;
		rd(8'h01, 8'h00);
		rd(8'h02, 8'hc0);
		rd(8'h03, 8'hff);
		rd(8'hff, 8'hff);
		wr(8'h01, 8'hff);
		rd(8'h01, 8'h00);
		wr(8'h02, 8'hff);
		rd(8'h02, 8'hfe);
		for (int i = 1; i < 6; i++) begin
			v = ~(8'h01 << i);
			wr(8'h03, v);
			rd(8'h03, v);
			settle();
			chk({3'h0, supply_on}, {3'h0, v[5:1]});
		end
		wr(8'h03, 8'h00);
		rd(8'h03, 8'hc1);
		@(posedge sys_clk) #1 undervoltage_lockout = 1;
		@(posedge sys_clk) #1 undervoltage_lockout = 0;
		rd(8'h03, 8'hff);
		want.buck_pin = 3'b110;
		want.lreg_pin = 0;
		settle();
		wr(8'h03, 8'h00);
		rd(8'h03, 8'he7);
		settle();
		chk({3'h0, supply_on}, 8'h00);
		want.buck_pin = 3'b111;
		want.lreg_pin = 1;
		wr(8'h03, 8'hff);
		want.pfail = 1;
		want.lbat = 1;
		want.buck_pg_low = 3'b111;
		want.lreg_pg_low = 2'b11;
		settle();
		rd(8'h01, 8'hfe);
		alert(0);
		want.dvs_busy = 1;
		settle();
		rd(8'h01, 8'hf6);
		wr(8'h03, 8'hdf);
		settle();
		rd(8'h01, 8'hd6);
		want = '0;
		want.buck_pin = 3'b111;
		want.lreg_pin = 1;
		want.buck_pg_low = 3'b010;
		wr(8'h03, 8'hff);
		wr(8'h02, 8'h00);
		settle();
		alert(1);
		rd(8'h01, 8'h10);
		alert(0);
		want.buck_pg_low = 3'b000;
		settle();
		want.buck_pg_low = 3'b010;
		settle();
		alert(1);
		wr(8'h02, 8'h10);
		settle();
		alert(0);
		rd(8'h01, 8'h10);
		sa = 7'h49;
		wr(8'h02, 8'h00);
		sa = `SSM_SLAVE_ADDR;
		rd(8'h02, 8'h10);
		finish_test();
	end
endmodule
